// *** rsq_bkpl.sv ***
`timescale 1ns/1ps
module rsq_bkpl (
	// Backplane
	input wire logic [7:0] ext_pull,
	input wire logic [7:0] ttl_out,
	input wire logic [7:0] ttl_oe,
	output logic [7:0] line
);
	assign line = ~(ext_pull | (ttl_oe & ~ttl_out));
endmodule // rsq_bkpl

// *** rsq_cfg.svh ***
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH
// Operation
// - Reset clears every module open dwell
// - Open dwell accepted only up to 6.5535 s
// - Separate open dwell per module, waited after open
// - Low-going TTL source pulse is one event
// - After trigger delay, open current relay
// - After open dwell, close next relay
// - After close dwell, pulse enabled lines 3 us
// - Reset disables all TTL trigger outputs
// - Independent per-line enables, disabled never driven
// - Enable query returns 1 or 0
// - Event n opens n-1, closes n
// - Ignore events until armed by initiate

// Time base and pulse width
`define RSQ_TICK_NS 100000
`define RSQ_PULSE_NS 3000
`define RSQ_CLK_NS 4
`define RSQ_TICK_CYC (`RSQ_TICK_NS / `RSQ_CLK_NS)
`define RSQ_PULSE_CYC (`RSQ_PULSE_NS / `RSQ_CLK_NS)
// Largest dwell count, 6.5535 s in 100 us units
`define RSQ_DWELL_MAX 16'hFFFF
`define RSQ_DWELL_RST 16'h0000
`define RSQ_EN_RST 8'h00
`endif

// *** rsq_pkg.sv ***
package rsq_pkg;
	typedef enum logic [2:0] {
		RSQ_IDLE = 3'b000,
		RSQ_TDLY = 3'b001,
		RSQ_ODWL = 3'b010,
		RSQ_CDWL = 3'b011,
		RSQ_PULS = 3'b100
	} rsq_state_e;
	typedef struct packed {
		logic open_v;
		logic close_v;
		logic [7:0] open_idx;
		logic [7:0] close_idx;
	} rsq_relay_s;
endpackage

// *** rsq_seq.sv ***
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_seq import rsq_pkg::*; #(
	parameter int NMOD = 4,
	parameter int NTTL = 8,
	parameter int TICK_CYC = `RSQ_TICK_CYC,
	parameter int PULSE_CYC = `RSQ_PULSE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Configuration writes
	input wire logic odwell_we,
	input wire logic [$clog2(NMOD)-1:0] odwell_mod,
	input wire logic [16:0] odwell_val,
	output logic odwell_err,
	input wire logic ttl_en_we,
	input wire logic [2:0] ttl_en_idx,
	input wire logic [15:0] ttl_en_val,
	input wire logic [2:0] ttl_q_idx,
	output logic ttl_q_on,
	input wire logic [15:0] cdwell,
	input wire logic [15:0] tdelay,
	// Scan control
	input wire logic initiate,
	input wire logic abort,
	input wire logic [$clog2(NMOD)-1:0] cur_mod,
	input wire logic [2:0] src_sel,
	input wire logic [NTTL-1:0] ttl_in,
	// Relay commands and TTL outputs
	output rsq_relay_s relay_q,
	output logic [NTTL-1:0] ttl_out,
	output logic [NTTL-1:0] ttl_oe,
	output logic busy
);
	logic [15:0] odwell_q [NMOD];
	logic [NTTL-1:0] ttl_en_q;
	logic armed_q;
	logic [NTTL-1:0] ttl_prev_q;
	rsq_state_e st_q;
	logic [15:0] cnt_q;
	logic [$clog2(TICK_CYC)-1:0] tick_q;
	logic [$clog2(PULSE_CYC+1)-1:0] pls_q;
	logic [7:0] idx_q;
	logic first_q;
	logic tick;
	logic event_in;

	////////////////////////////////////////////////////////////////////////
	// range check
	always_ff @(posedge mclk) begin
		if (srst) begin
			odwell_err <= 1'b0;
		end else begin
			odwell_err <= odwell_we && (odwell_val > {1'b0, `RSQ_DWELL_MAX});
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < NMOD; i++) begin
				odwell_q[i] <= `RSQ_DWELL_RST;
			end
		end else if (odwell_we && odwell_val <= {1'b0, `RSQ_DWELL_MAX}) begin
			odwell_q[odwell_mod] <= odwell_val[15:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ttl_en_q <= `RSQ_EN_RST;
		end else if (ttl_en_we) begin
			ttl_en_q[ttl_en_idx] <= (ttl_en_val != 16'h0000);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ttl_q_on <= 1'b0;
		end else begin
			ttl_q_on <= ttl_en_q[ttl_q_idx];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// falling edge on source line
	always_ff @(posedge mclk) begin
		if (srst) begin
			ttl_prev_q <= '1;
		end else begin
			ttl_prev_q <= ttl_in;
		end
	end
	assign event_in = ttl_prev_q[src_sel] && !ttl_in[src_sel];

	always_ff @(posedge mclk) begin
		if (srst) begin
			armed_q <= 1'b0;
		end else if (abort) begin
			armed_q <= 1'b0;
		end else if (initiate) begin
			armed_q <= 1'b1;
		end
	end

	// 100 us tick divider
	// Restart at each count load so no dwell unit is cut short
	always_ff @(posedge mclk) begin
		if (srst || st_q == RSQ_IDLE || cnt_q == 16'h0000) begin
			tick_q <= '0;
		end else if (tick_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + 1'b1;
		end
	end
	assign tick = (tick_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Step sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= RSQ_IDLE;
			cnt_q <= 16'h0000;
			pls_q <= '0;
			idx_q <= 8'h00;
			first_q <= 1'b1;
			relay_q <= '0;
		end else begin
			relay_q.open_v <= 1'b0;
			relay_q.close_v <= 1'b0;
			unique case (st_q)
				RSQ_IDLE: begin
					if (armed_q && event_in) begin
						st_q <= RSQ_TDLY;
						cnt_q <= tdelay;
					end
				end
				RSQ_TDLY: begin
					if (cnt_q == 16'h0000) begin
						// open current, skip on first event
						relay_q.open_v <= !first_q;
						relay_q.open_idx <= idx_q - 8'h01;
						cnt_q <= odwell_q[cur_mod];
						st_q <= RSQ_ODWL;
					end else if (tick) begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				RSQ_ODWL: begin
					if (cnt_q == 16'h0000) begin
						relay_q.close_v <= 1'b1;
						relay_q.close_idx <= idx_q;
						idx_q <= idx_q + 8'h01;
						first_q <= 1'b0;
						cnt_q <= cdwell;
						st_q <= RSQ_CDWL;
					end else if (tick) begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				RSQ_CDWL: begin
					if (cnt_q == 16'h0000) begin
						pls_q <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
						st_q <= RSQ_PULS;
					end else if (tick) begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				RSQ_PULS: begin
					if (pls_q == ($clog2(PULSE_CYC+1))'(1)) begin
						st_q <= RSQ_IDLE;
					end
					pls_q <= pls_q - 1'b1;
				end
				default: begin
					st_q <= RSQ_IDLE;
				end
			endcase
		end
	end

	// drive only enabled lines, eight lines
	always_ff @(posedge mclk) begin
		if (srst) begin
			ttl_oe <= '0;
		end else begin
			ttl_oe <= (st_q == RSQ_PULS && pls_q != '0) ? ttl_en_q : '0;
		end
	end
	assign ttl_out = '0;
	assign busy = (st_q != RSQ_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Checks
	// reset stops drive
	a_reset_no_drive: assert property (@(posedge mclk)
		srst |=> ttl_oe == '0) else $error("trigger driven after reset");
	a_disabled_idle: assert property (@(posedge mclk)
		disable iff (srst)
		(ttl_oe & ~$past(ttl_en_q)) == '0) else $error("disabled line driven");
	a_unarmed_ignore: assert property (@(posedge mclk)
		disable iff (srst)
		st_q == RSQ_IDLE && !armed_q |=> st_q == RSQ_IDLE)
		else $error("event taken unarmed");
	a_close_after_open: assert property (@(posedge mclk)
		disable iff (srst)
		st_q == RSQ_ODWL && cnt_q == 16'h0000 |=> relay_q.close_v)
		else $error("close missing");
	a_open_after_delay: assert property (@(posedge mclk)
		disable iff (srst)
		st_q == RSQ_TDLY && cnt_q == 16'h0000 |=> st_q == RSQ_ODWL)
		else $error("open step missing");
	a_dwell_reset: assert property (@(posedge mclk)
		srst |=> odwell_q[0] == `RSQ_DWELL_RST) else $error("dwell not cleared");
	a_range_reject: assert property (@(posedge mclk)
		disable iff (srst)
		odwell_we && odwell_val[16] |=> odwell_err && $stable(odwell_q[0]))
		else $error("bad dwell accepted");
	a_query_value: assert property (@(posedge mclk)
		disable iff (srst)
		1'b1 |=> ttl_q_on == $past(ttl_en_q[ttl_q_idx]))
		else $error("query wrong");
	a_pulse_start: assert property (@(posedge mclk)
		disable iff (srst)
		st_q == RSQ_CDWL && cnt_q == 16'h0000 |=> st_q == RSQ_PULS)
		else $error("pulse missing");
	c_step_done: cover property (@(posedge mclk) relay_q.close_v);
	c_pulse: cover property (@(posedge mclk) ttl_oe != '0);
	c_second_open: cover property (@(posedge mclk) relay_q.open_v);
endmodule // rsq_seq

// *** tb.sv ***
`timescale 1ns/1ps
module tb import rsq_pkg::*;;
	logic mclk = 0, srst = 1, odwell_we = 0, ttl_en_we = 0;
	logic initiate = 0, abort = 0, odwell_err, ttl_q_on, busy, ov, e, bz;
	logic [1:0] odwell_mod = 0, cur_mod = 0;
	logic [16:0] odwell_val = 0;
	logic [2:0] ttl_en_idx = 0, ttl_q_idx = 0, src_sel = 3'h2;
	logic [15:0] ttl_en_val = 0, cdwell = 0, tdelay = 0;
	logic [7:0] pull = 0, ttl_in, ttl_out, ttl_oe, oi, ci, oe;
	rsq_relay_s relay_q;
	int bad_count = 0, check_count = 0, t, g, w;
	always #2 mclk = ~mclk;
	rsq_seq #(.NMOD(4), .TICK_CYC(4), .PULSE_CYC(750)) i_rsq_seq (
		.mclk(mclk), .srst(srst),
		.odwell_we(odwell_we), .odwell_mod(odwell_mod),
		.odwell_val(odwell_val), .odwell_err(odwell_err),
		.ttl_en_we(ttl_en_we), .ttl_en_idx(ttl_en_idx),
		.ttl_en_val(ttl_en_val), .ttl_q_idx(ttl_q_idx),
		.ttl_q_on(ttl_q_on), .cdwell(cdwell), .tdelay(tdelay),
		.initiate(initiate), .abort(abort), .cur_mod(cur_mod),
		.src_sel(src_sel), .ttl_in(ttl_in), .relay_q(relay_q),
		.ttl_out(ttl_out), .ttl_oe(ttl_oe), .busy(busy));
	rsq_bkpl i_rsq_bkpl (.ext_pull(pull), .ttl_out(ttl_out),
		.ttl_oe(ttl_oe), .line(ttl_in));
	////////////////////////////////////////
	task automatic chk(string s, logic [31:0] x, logic [31:0] y);
		check_count++;
		if (y !== x) begin
			bad_count++;
			$display("mismatch %s expected %0h seen %0h", s, x, y);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic odw(logic [1:0] m, logic [16:0] v);
		odwell_mod = m;
		odwell_val = v;
		odwell_we = 1;
		tick(1);
		odwell_we = 0;
		e = odwell_err;
		tick(1);
		e = e | odwell_err;
	endtask
	task automatic en(logic [2:0] i, logic [15:0] v);
		ttl_en_idx = i;
		ttl_en_val = v;
		ttl_en_we = 1;
		tick(1);
		ttl_en_we = 0;
		tick(1);
	endtask
	task automatic ask(logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			ttl_q_idx = i[2:0];
			tick(2);
			chk("en_query", {31'h0, m[i]}, {31'h0, ttl_q_on});
		end
	endtask
	task automatic step();
		ov = 0;
		t = 0;
		g = 0;
		w = 0;
		pull[2] = 1;
		tick(1);
		pull[2] = 0;
		while (relay_q.close_v !== 1'b1 && t < 900) begin
			tick(1);
			t++;
			g++;
			if (relay_q.open_v === 1'b1) begin
				ov = 1;
				oi = relay_q.open_idx;
				g = 0;
			end
		end
		ci = relay_q.close_idx;
		bz = busy;
		while (ttl_oe === 8'h00 && w < 900) begin
			tick(1);
			w++;
		end
		oe = ttl_oe;
		w = 0;
		while (ttl_oe !== 8'h00 && w < 900) begin
			tick(1);
			w++;
		end
		tick(2);
	endtask
	////////////////////////////////////////
	task automatic s_reset();
		chk("oe_rst", 8'h00, ttl_oe);
		ask(8'h00);
	endtask
	task automatic s_range();
		odw(2'h0, 17'h1_0000);
		chk("dwell_err", 1, e);
		odw(2'h0, 17'h0_ffff);
		chk("dwell_ok", 0, e);
		odw(2'h0, 17'h0_0003);
	endtask
	task automatic s_en();
		en(3'h0, 16'h0002);
		en(3'h7, 16'h0001);
		en(3'h3, 16'h0001);
		en(3'h3, 16'h0000);
		ask(8'h81);
	endtask
	task automatic s_unarmed();
		step();
		chk("unarmed", 0, ov | (t < 900));
		chk("busy_idle", 0, bz);
	endtask
	task automatic s_first();
		initiate = 1;
		tick(1);
		initiate = 0;
		cur_mod = 2'h1;
		step();
		chk("first_open", 0, ov);
		chk("first_close", 8'h00, ci);
		chk("pulse_lines", 8'h81, oe);
		chk("pulse_width", 750, w);
		chk("busy_run", 1, bz);
	endtask
	task automatic s_second();
		step();
		chk("open_idx", 8'h00, oi);
		chk("close_idx", 8'h01, ci);
		chk("gap_zero", 1, ov & (g == 1));
	endtask
	task automatic s_third();
		cur_mod = 2'h0;
		tdelay = 16'h0002;
		step();
		chk("next_pair", 16'h0102, {oi, ci});
		chk("gap_dwell", 13, g);
		chk("delay", 9, t - g);
	endtask
	task automatic s_abort();
		abort = 1;
		tick(1);
		abort = 0;
		pull[2] = 1;
		tick(1);
		pull[2] = 0;
		tick(2);
		chk("abort_busy", 0, busy);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		tick(20);
		srst = 0;
		s_reset();
		s_range();
		s_en();
		s_unarmed();
		s_first();
		s_second();
		s_third();
		s_abort();
		results();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		results();
	end
endmodule // tb
